/* File: rtl/tocl_top.sv */
/*
 * Threshold output control: two independent switched outputs, set directly from process
 * data or automatically from counter or frequency thresholds, with timestamps and a
 * bus-fault fallback.
 * Assumes counter, frequency and process data come from logic on clk; the bus-fault
 * indication arrives asynchronously and is synchronised here.
 */
//
// Contract
// - two outputs, index 0 and 1, each with fully separate configuration and logic.
// - drive setting 0 drives high for TRUE and low for FALSE.
// - drive setting 1 drives high for TRUE, high impedance for FALSE.
// - with automatic switching off, the output follows the host-requested level.
// - counter mode compares against up to eight thresholds and switches on reaching one.
// - each counter threshold carries its own target level.
// - each counter threshold carries a duration for holding its level.
// - a timestamp is captured and reported whenever a threshold switches the output.
// - frequency mode uses at most two thresholds against the measured frequency.
// - frequency mode: first threshold gives TRUE, second gives FALSE, fixed.
// - frequency mode has no timed hold; level stays until another threshold.
// - each output has a fallback enable deciding behaviour on a bus fault.
// - bus fault with fallback enabled and level TRUE switches the output on; in CH_WAIT, before the first frame, the fault is ignored.
// - bus fault with fallback enabled and level FALSE switches the output off.
// - bus fault with fallback disabled keeps the present level, ignores fallback level.
// - control values enter per output; feedback and status return on separate ports.
// - host supplies thresholds; device switches on its own, independent of host cycle.
// - automatic switching enabled means direct level requests are ignored.
// - with automatic switching off, a tristate request places output in high impedance whatever the requested level.
// - duration limited to 24000 us; zero holds level until the next threshold.
// - each reported threshold timestamp is 64 bits wide.
`timescale 1ns/100ps
`default_nettype none

`include "tocl_defines.svh"

module tocl_top #(
    parameter int NUM_CAMS = 8,
    parameter int VAL_W    = 32,
    parameter int DUR_W    = 15,
    parameter int CNT_W    = 4
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    // measured values
    input  wire logic [VAL_W-1:0]                counterValue,
    input  wire logic [VAL_W-1:0]                freqValue,
    input  wire logic                            busFaultPin,

    // process data, one bit or field per output; pdValid is one bit for both
    input  wire logic                            pdValid,
    input  wire logic [1:0]                      setLevel,
    input  wire logic [1:0]                      setTristate,
    input  wire logic [1:0]                      autoEnable,
    input  wire logic [2*NUM_CAMS*VAL_W-1:0]     thrValue,
    input  wire logic [2*NUM_CAMS-1:0]           thrLevel,
    input  wire logic [2*NUM_CAMS*DUR_W-1:0]     thrDuration,
    input  wire logic [2*CNT_W-1:0]              active_cam_count,

    // configuration, one bit or field per output
    input  wire logic [1:0]                      driveMode,
    input  wire logic [1:0]                      baseMode,
    input  wire logic [1:0]                      disableCw,
    input  wire logic [1:0]                      disableCcw,
    input  wire logic [1:0]                      bus_fault_fallback_enable,
    input  wire logic [1:0]                      bus_fault_fallback_level,

    // pins and status
    output var  logic [1:0]                      outPin,
    output var  logic [1:0]                      outPinOe,
    output var  logic [1:0]                      outFeedback,
    output var  logic [1:0]                      outFault,
    output var  logic [1:0]                      tsStrobe,
    output var  logic [2*`TOCL_TS_W-1:0]         timestamp
);
    import tocl_pkg::*;

    localparam int IDX_W = (NUM_CAMS > 1) ? $clog2(NUM_CAMS) : 1;
    localparam logic [DUR_W-1:0] DUR_MAX = DUR_W'(`TOCL_DUR_MAX_US);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // bit 1: reached moving up (cw), bit 0: reached moving down (ccw)
    function automatic logic [1:0] crossed(input logic [VAL_W-1:0] prev,
                                           input logic [VAL_W-1:0] cur,
                                           input logic [VAL_W-1:0] thr);
        crossed = {(prev < thr) && (cur >= thr), (prev > thr) && (cur <= thr)};
    endfunction : crossed

    function automatic logic [DUR_W-1:0] clampDur(input logic [DUR_W-1:0] d);
        clampDur = (d > DUR_MAX) ? DUR_MAX : d;
    endfunction : clampDur

    // ------------------------------------------------------------------------
    // shared time base and fault synchroniser
    // ------------------------------------------------------------------------
    logic                  usTick;
    logic [`TOCL_TS_W-1:0] nowNs;
    logic                  busFault;

    tocl_timebase u_timebase (
        .clk    (clk),
        .rstn   (rstn),
        .usTick (usTick),
        .nowNs  (nowNs)
    );

    tocl_sync #(.WIDTH(1)) u_fault_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (busFaultPin),
        .dout (busFault)
    );

    // ------------------------------------------------------------------------
    // per-output switching channel
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_chan
        tocl_chan_state_t      state;
        tocl_chan_state_t      next_state;
        logic                  level;
        logic                  next_level;
        logic                  triOn;
        logic                  next_tri;

        logic [DUR_W-1:0]      timer;
        logic [DUR_W-1:0]      next_timer;
        logic [VAL_W-1:0]      prevValue;
        logic [VAL_W-1:0]      curValue;
        logic                  hit;
        logic [IDX_W-1:0]      hitIdx;
        logic [CNT_W-1:0]      camLimit;
        logic [CNT_W-1:0]      camCount;

        logic                  next_pin;
        logic                  next_oe;
        logic                  next_strobe;
        logic [`TOCL_TS_W-1:0] stamp;
        logic [`TOCL_TS_W-1:0] next_stamp;
        logic [DUR_W-1:0]      hitDur;

        assign camCount = active_cam_count[g*CNT_W +: CNT_W];

        // ------------------------------------------------------------
        // threshold detection
        // ------------------------------------------------------------
        // the lowest reached index wins when several are passed at once
        always_comb begin
            logic [1:0] dir;
            dir      = 2'b00;
            hit      = 1'b0;
            hitIdx   = '0;
            curValue = (baseMode[g] == `TOCL_BASE_FREQ) ? freqValue : counterValue;
            if (baseMode[g] == `TOCL_BASE_FREQ) begin
                camLimit = (camCount > CNT_W'(`TOCL_FREQ_CAMS)) ? CNT_W'(`TOCL_FREQ_CAMS) : camCount;
            end else begin
                camLimit = (camCount > CNT_W'(NUM_CAMS)) ? CNT_W'(NUM_CAMS) : camCount;
            end

            for (int i = NUM_CAMS - 1; i >= 0; i--) begin
                dir = crossed(prevValue, curValue, thrValue[(g*NUM_CAMS+i)*VAL_W +: VAL_W]);
                // counting-direction masks apply to counter mode only
                if (baseMode[g] == `TOCL_BASE_COUNTER) begin
                    dir = dir & {~disableCw[g], ~disableCcw[g]};
                end
                if ((CNT_W'(i) < camLimit) && (dir != 2'b00)) begin
                    hit    = 1'b1;
                    hitIdx = IDX_W'(i);
                end
            end

            hitDur = clampDur(thrDuration[(g*NUM_CAMS+int'(hitIdx))*DUR_W +: DUR_W]);
        end

        // ------------------------------------------------------------
        // channel state and output level
        // ------------------------------------------------------------
        always_comb begin
            next_state  = state;
            next_level  = level;
            next_tri    = triOn;
            next_timer  = timer;
            next_stamp  = stamp;
            next_strobe = 1'b0;
            case (state)
                CH_WAIT: begin
                    // outputs stay inactive until the host has sent valid data
                    next_level = 1'b0;
                    next_tri   = 1'b0;
                    if (pdValid) begin
                        next_state = CH_RUN;
                    end
                end

                CH_RUN, CH_HOLD: begin
                    if (busFault) begin
                        next_state = CH_FAULT;
                        if (bus_fault_fallback_enable[g]) begin
                            next_level = bus_fault_fallback_level[g];
                            next_tri   = 1'b0;
                        end
                        // otherwise level and tristate are simply kept
                    end else if (!autoEnable[g]) begin
                        next_state = CH_RUN;
                        next_level = setLevel[g];
                        next_tri   = setTristate[g];
                    end else begin
                        // direct requests are ignored while switching is automatic
                        next_tri = 1'b0;
                        if (hit) begin
                            next_strobe = 1'b1;
                            next_stamp  = nowNs;
                            if (baseMode[g] == `TOCL_BASE_FREQ) begin
                                next_level = (hitIdx == '0) ? `TOCL_FREQ_ON_LEVEL : `TOCL_FREQ_OFF_LEVEL;
                                next_state = CH_RUN;
                            end else begin
                                next_level = thrLevel[g*NUM_CAMS+int'(hitIdx)];
                                if (hitDur != '0) begin
                                    next_timer = hitDur;
                                    next_state = CH_HOLD;
                                end else begin
                                    next_state = CH_RUN;
                                end
                            end
                        end else if ((state == CH_HOLD) && usTick) begin
                            // a timed cam ends by returning to the opposite level
                            if (timer <= DUR_W'(1)) begin
                                next_timer = '0;
                                next_level = ~level;
                                next_state = CH_RUN;
                            end else begin
                                next_timer = timer - DUR_W'(1);
                            end
                        end
                    end
                end

                CH_FAULT: begin
                    // level is frozen for the whole fault; control resumes once it clears
                    if (!busFault) begin
                        next_state = CH_RUN;
                    end
                end

                default: begin
                    next_state = CH_WAIT;
                end
            endcase
        end

        // ------------------------------------------------------------
        // pin drive from level, tristate request and drive characteristic
        // ------------------------------------------------------------
        always_comb begin
            next_pin = next_level & ~next_tri;
            if (next_tri) begin
                next_oe = 1'b0;
            end else if (driveMode[g] == `TOCL_DRIVE_PUSHTRI) begin
                next_oe = next_level;
            end else begin
                next_oe = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // registers
        // ------------------------------------------------------------
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                state          <= CH_WAIT;
                level          <= 1'b0;
                triOn          <= 1'b0;
                timer          <= '0;
                prevValue      <= '0;
                stamp          <= '0;

                outPin[g]      <= 1'b0;
                outPinOe[g]    <= 1'b0;
                outFeedback[g] <= 1'b0;
                outFault[g]    <= 1'b0;
                tsStrobe[g]    <= 1'b0;
                timestamp[g*`TOCL_TS_W +: `TOCL_TS_W] <= '0;
            end else begin
                state          <= next_state;
                level          <= next_level;
                triOn          <= next_tri;
                timer          <= next_timer;
                prevValue      <= curValue;
                stamp          <= next_stamp;

                outPin[g]      <= next_pin;
                outPinOe[g]    <= next_oe;
                outFeedback[g] <= next_level;
                outFault[g]    <= (next_state == CH_FAULT);
                tsStrobe[g]    <= next_strobe;
                timestamp[g*`TOCL_TS_W +: `TOCL_TS_W] <= next_stamp;
            end
        end
    end

endmodule : tocl_top

`default_nettype wire

/* File: rtl/tocl_defines.svh */
/*
 * Constants for the threshold output control block: timing, drive and base-value encodings.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef TOCL_DEFINES_SVH
`define TOCL_DEFINES_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define TOCL_CLK_PERIOD_NS 4
`define TOCL_US_NS         1000
`define TOCL_US_CYCLES     (`TOCL_US_NS / `TOCL_CLK_PERIOD_NS)
`define TOCL_DUR_MAX_US    24000
`define TOCL_TS_W          64

// ----------------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------------
`define TOCL_DRIVE_PUSHPULL 1'b0
`define TOCL_DRIVE_PUSHTRI  1'b1
`define TOCL_BASE_COUNTER   1'b0
`define TOCL_BASE_FREQ      1'b1
`define TOCL_FREQ_CAMS      2
`define TOCL_FREQ_ON_LEVEL  1'b1
`define TOCL_FREQ_OFF_LEVEL 1'b0

`endif

/* File: rtl/tocl_pkg.sv */
/*
 * Types shared by the threshold output control block.
 * Assumes nothing of its surroundings.
 */
package tocl_pkg;

    typedef enum logic [1:0] {
        CH_WAIT,
        CH_RUN,
        CH_HOLD,
        CH_FAULT
    } tocl_chan_state_t;

endpackage : tocl_pkg

/* File: rtl/tocl_sync.sv */
/*
 * Two-flop synchroniser for levels arriving from outside the clock domain.
 * Assumes the input is a slow level; pulses shorter than one cycle may be lost.
 */
`timescale 1ns/100ps
`default_nettype none

module tocl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : tocl_sync

`default_nettype wire

/* File: rtl/tocl_timebase.sv */
/*
 * Local time base: a one-cycle microsecond enable and a free-running nanosecond timestamp.
 * Assumes clk runs at the period given in the defines header.
 */
`timescale 1ns/100ps
`default_nettype none

`include "tocl_defines.svh"

module tocl_timebase (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    output var  logic                  usTick,
    output var  logic [`TOCL_TS_W-1:0] nowNs
);
    localparam logic [15:0] US_LAST = 16'(`TOCL_US_CYCLES - 1);

    logic [15:0]           divCount;
    logic [15:0]           next_divCount;
    logic                  next_usTick;
    logic [`TOCL_TS_W-1:0] next_nowNs;

    always_comb begin
        next_usTick   = (divCount == US_LAST);
        next_divCount = next_usTick ? 16'h0000 : divCount + 16'h0001;
        next_nowNs    = nowNs + `TOCL_TS_W'(`TOCL_CLK_PERIOD_NS);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCount <= 16'h0000;
            usTick   <= 1'b0;
            nowNs    <= '0;
        end else begin
            divCount <= next_divCount;
            usTick   <= next_usTick;
            nowNs    <= next_nowNs;
        end
    end

endmodule : tocl_timebase

`default_nettype wire

/* File: tb/tocl_master_model.sv */
/* Fieldbus master model: cyclic process-data frames and the bus-fault line.
   Assumes the bench raises send for one cycle per frame. */
`timescale 1ns/100ps
`default_nettype none

module tocl_master_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       send,
    input  wire logic [1:0] reqLevel,
    input  wire logic [1:0] reqTri,
    input  wire logic [1:0] reqAuto,
    input  wire logic       reqFault,
    output var  logic       pdValid,
    output var  logic [1:0] setLevel,
    output var  logic [1:0] setTristate,
    output var  logic [1:0] autoEnable,
    output var  logic       busFaultPin
);
    // fields hold between frames, as cyclic process data does
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {pdValid, setLevel, setTristate, autoEnable, busFaultPin} <= '0;
        end else begin
            pdValid     <= send;
            busFaultPin <= reqFault;
            if (send) begin
                setLevel    <= reqLevel;
                setTristate <= reqTri;
                autoEnable  <= reqAuto;
            end
        end
    end
endmodule : tocl_master_model

`default_nettype wire

/* File: tb/tocl_top_asserts.sv */
/* Checker for tocl_top: drive modes, direct control, stamps and bus-fault fallback.
   Assumes a bind to tocl_top and one clock domain. */
`timescale 1ns/100ps
`default_nettype none

`include "tocl_defines.svh"

module tocl_top_asserts (
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire logic                    busFaultPin,
    input wire logic                    pdValid,
    input wire logic [1:0]              setLevel,
    input wire logic [1:0]              setTristate,
    input wire logic [1:0]              autoEnable,
    input wire logic [1:0]              driveMode,
    input wire logic [1:0]              bus_fault_fallback_enable,
    input wire logic [1:0]              bus_fault_fallback_level,
    input wire logic [1:0]              outPin,
    input wire logic [1:0]              outPinOe,
    input wire logic [1:0]              outFeedback,
    input wire logic [1:0]              outFault,
    input wire logic [1:0]              tsStrobe,
    input wire logic [2*`TOCL_TS_W-1:0] timestamp
);
    logic pdSeen, live2, live;

    // live: three cycles after the first frame, outputs reflect process data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {pdSeen, live2, live} <= 3'h0;
        end else begin
            {pdSeen, live2, live} <= {pdSeen | pdValid, pdSeen, live2};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_faultHeld;
        $rose(busFaultPin) ##1 busFaultPin [*3];
    endsequence

    property p_idle; !pdSeen |-> outPin == 2'h0 && outFeedback == 2'h0; endproperty
    a_idle: assert property (p_idle) else $error("output active before first frame");
    property p_pushPull;
        $past(rstn) && $past(driveMode[0] == 1'b0 && !setTristate[0] && !outFault[0]) && !outFault[0] |-> outPinOe[0];
    endproperty
    a_pushPull: assert property (p_pushPull) else $error("push-pull output not driven");
    property p_pushTri; $past(driveMode[1]) && outPinOe[1] |-> outPin[1]; endproperty
    a_pushTri: assert property (p_pushTri) else $error("push-tristate drives low");
    property p_direct;
        live && $past(!autoEnable[0] && !setTristate[0] && !outFault[0]) && !outFault[0]
            |-> outFeedback[0] == $past(setLevel[0]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct level not followed");
    property p_tri; live && $past(setTristate[1] && !autoEnable[1] && !outFault[1]) && !outFault[1] |-> !outPinOe[1];
    endproperty
    a_tri: assert property (p_tri) else $error("tristate request still driven");
    property p_tsHold; !tsStrobe[0] |-> $stable(timestamp[63:0]); endproperty
    a_tsHold: assert property (p_tsHold) else $error("stamp moved without strobe");
    property p_tsCause; tsStrobe[1] |-> $past(autoEnable[1]); endproperty
    a_tsCause: assert property (p_tsCause) else $error("stamp without automatic switching");
    property p_faultOn;
        s_faultHeld ##0 (bus_fault_fallback_enable[1] && bus_fault_fallback_level[1])
            |-> outFault[1] && outFeedback[1] && outPin[1] && outPinOe[1];
    endproperty
    a_faultOn: assert property (p_faultOn) else $error("fallback on not applied");
    property p_faultOff;
        s_faultHeld ##0 (bus_fault_fallback_enable[0] && !bus_fault_fallback_level[0])
            |-> outFault[0] && !outFeedback[0] && !outPin[0];
    endproperty
    a_faultOff: assert property (p_faultOff) else $error("fallback off not applied");
    property p_faultKeep;
        outFault[0] && $past(outFault[0]) && !bus_fault_fallback_enable[0]
            |-> $stable(outFeedback[0]) && $stable(outPinOe[0]);
    endproperty
    a_faultKeep: assert property (p_faultKeep) else $error("level moved during fault");
endmodule : tocl_top_asserts

bind tocl_top tocl_top_asserts tocl_top_asserts_i (
    .clk, .rstn, .busFaultPin, .pdValid, .setLevel, .setTristate, .autoEnable, .driveMode,
    .bus_fault_fallback_enable, .bus_fault_fallback_level, .outPin, .outPinOe, .outFeedback,
    .outFault, .tsStrobe, .timestamp
);

`default_nettype wire

/* File: tb/tb_top.sv */
/* Bench for tocl_top: direct, counter, frequency and bus-fault sequences.
   Assumes the master model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none

`include "tocl_defines.svh"

module tb_top;
    logic         clk, rstn, send, reqFault, pdValid, busFaultPin;
    logic [1:0]   reqLevel, reqTri, reqAuto, setLevel, setTristate, autoEnable;
    logic [31:0]  counterValue, freqValue;
    logic [511:0] thrValue;
    logic [15:0]  thrLevel;
    logic [239:0] thrDuration;
    logic [7:0]   camCount;
    logic [1:0]   driveMode, baseMode, disableCw, disableCcw, fbEn, fbLvl;
    logic [1:0]   outPin, outPinOe, outFeedback, outFault, tsStrobe;
    logic [127:0] timestamp;
    logic [63:0]  ts0;
    int           nMismatch, testsRun, t0, t1, n;
    int           cyc = 0;
    logic [1:0]   lvl [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    logic [1:0]   trs [4] = '{2'h3, 2'h0, 2'h0, 2'h0};
    logic [1:0]   eOe [4] = '{2'h0, 2'h1, 2'h1, 2'h3};

    tocl_top tocl_top_i (
        .clk, .rstn, .counterValue, .freqValue, .busFaultPin, .pdValid, .setLevel, .setTristate, .autoEnable,
        .thrValue, .thrLevel, .thrDuration, .active_cam_count(camCount), .driveMode, .baseMode, .disableCw,
        .disableCcw, .bus_fault_fallback_enable(fbEn), .bus_fault_fallback_level(fbLvl), .outPin, .outPinOe,
        .outFeedback, .outFault, .tsStrobe, .timestamp
    );
    tocl_master_model tocl_master_model_i (
        .clk, .rstn, .send, .reqLevel, .reqTri, .reqAuto, .reqFault, .pdValid, .setLevel, .setTristate,
        .autoEnable, .busFaultPin
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        if (nMismatch == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // one frame from the master, then long enough for sync-free two-cycle latency
    task automatic pd(input logic [1:0] level, input logic [1:0] tris, input logic [1:0] aut);
        @(posedge clk);
        send     <= 1'b1;
        reqLevel <= level;
        reqTri   <= tris;
        reqAuto  <= aut;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : pd

    // kind 0 waits for a strobe, kind 1 for a high feedback level
    task automatic waitEv(input int kind, input int g, output int t);
        int i;
        for (i = 0; i < 1000; i++) begin
            @(posedge clk);
            #1;
            if ((kind == 0 ? tsStrobe[g] : outFeedback[g]) === 1'b1)
                break;
        end
        if (i == 1000) begin
            nMismatch++;
            summarize();
        end
        t = cyc;
    endtask : waitEv

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, send, reqFault, reqLevel, reqTri, reqAuto, counterValue, freqValue} <= '0;
        {thrValue, thrDuration, disableCw, disableCcw} <= '0;
        thrValue[63:0]       <= {32'hC8, 32'h64};
        thrValue[319:256]    <= {32'h50, 32'h32};
        thrDuration[29:15]   <= 15'h2;
        thrDuration[149:135] <= 15'h1;
        {thrLevel, camCount} <= {16'h0201, 8'h22};
        {driveMode, baseMode, fbEn, fbLvl} <= {2'h2, 2'h2, 2'h3, 2'h2};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({outFeedback, outPin, outPinOe}, 6'h01);
        for (int i = 0; i < 4; i++) begin
            pd(lvl[i], trs[i], 2'h0);
            chk(outPinOe, eOe[i]);
            chk(outPin & outPinOe, lvl[i] & eOe[i]);
        end
        pd(2'h0, 2'h0, 2'h1);
        @(posedge clk);
        counterValue <= 32'h96;
        waitEv(0, 0, t0);
        ts0 = timestamp[63:0];
        chk(outFeedback[0], 1'b1);
        repeat (600) @(posedge clk);
        #1;
        chk(outFeedback[0], 1'b1);
        @(posedge clk);
        counterValue <= 32'hFA;
        waitEv(0, 0, t1);
        chk(outFeedback[0], 1'b0);
        chk(timestamp[63:0] - ts0, 64'(`TOCL_CLK_PERIOD_NS * (t1 - t0)));
        pd(2'h1, 2'h0, 2'h1);
        chk(outFeedback[0], 1'b0);
        waitEv(1, 0, n);
        chk((n - t1) >= 251 && (n - t1) <= 500, 1'b1);
        pd(2'h1, 2'h0, 2'h3);
        @(posedge clk);
        freqValue <= 32'h3C;
        waitEv(0, 1, t0);
        ts0 = timestamp[127:64];
        chk({outPin[1], outPinOe[1], outFeedback[1], outFeedback[0]}, 4'hF);
        @(posedge clk);
        freqValue <= 32'h5A;
        waitEv(0, 1, t1);
        chk({outPinOe[1], outFeedback[1]}, 2'h0);
        chk(timestamp[127:64] - ts0, 64'(`TOCL_CLK_PERIOD_NS * (t1 - t0)));
        repeat (600) @(posedge clk);
        #1;
        chk(outFeedback[1], 1'b0);
        @(posedge clk);
        {disableCcw, counterValue, ts0} <= {2'h1, 32'h32, timestamp[63:0]};
        repeat (4) @(posedge clk);
        #1;
        chk(timestamp[63:0], ts0);
        @(posedge clk);
        reqFault <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({outFault, outFeedback, outPinOe}, 6'h3B);
        @(posedge clk);
        reqFault <= 1'b0;
        repeat (6) @(posedge clk);
        pd(2'h1, 2'h0, 2'h0);
        chk({outFault, outFeedback}, 4'h1);
        @(posedge clk);
        {fbEn, fbLvl, reqFault} <= {2'h0, 2'h2, 1'b1};
        repeat (6) @(posedge clk);
        pd(2'h2, 2'h0, 2'h0);
        chk({outFault, outFeedback}, 4'hD);
        pd(2'h2, 2'h0, 2'h0);
        @(posedge clk);
        reqFault <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({outFault, outFeedback}, 4'h2);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
